// ### src/asl_pkg.sv
// Constants and carrier types for the serial lane output block.
// Assumes a 100 MHz core clock, APB register access and a link clock.
package asl_pkg;

    localparam int CLK_NS = 10;
    localparam int WORD_W = 16;
    localparam int CNT_W  = 12;

    // Lane mode codes, shared by the strap pins and the control field
    localparam logic [1:0] MODE_TWO  = 2'h0;
    localparam logic [1:0] MODE_FOUR = 2'h1;
    localparam logic [1:0] MODE_ONE  = 2'h2;

    // Register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DCS_BIT  = 2;
    localparam int CTRL_DRV_LSB  = 3;
    localparam int CTRL_TERM_BIT = 6;

    // Status field positions
    localparam int ST_NAP_BIT  = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_SE_BIT   = 2;
    localparam int ST_MODE_LSB = 3;
    localparam int ST_PAR_BIT  = 5;
    localparam int ST_DCS_BIT  = 6;

    // Drive current codes: 1.75/2.1/2.5/3/3.5/4/4.5 mA as 0..6
    localparam logic [2:0] DRV_1P75MA = 3'h0;
    localparam logic [2:0] DRV_3P5MA  = 3'h4;

    // Reset values of the control register
    localparam logic [1:0] MODE_RST = MODE_TWO;
    localparam logic       DCS_RST  = 1'b1;
    localparam logic [2:0] DRV_RST  = DRV_3P5MA;
    localparam logic       TERM_RST = 1'b0;

    // Nap when no encode edge for one 500 kHz period
    localparam int NAP_NS = 2000;
    localparam logic [CNT_W-1:0] NAP_CYC = CNT_W'(NAP_NS / CLK_NS);
    // Relock time after restart or frequency change
    localparam int LOCK_NS = 25000;
    localparam logic [CNT_W-1:0] LOCK_CYC =
        CNT_W'((LOCK_NS + CLK_NS - 1) / CLK_NS);
    // Period jitter tolerated before a relock
    localparam logic [CNT_W-1:0] PER_TOL = 12'h002;

    typedef struct packed {
        logic fwd_data_clock;
        logic frame_marker;
        logic ch1_lane_a;
        logic ch1_lane_b;
        logic ch1_lane_c;
        logic ch1_lane_d;
        logic ch2_lane_a;
        logic ch2_lane_b;
        logic ch2_lane_c;
        logic ch2_lane_d;
    } asl_link_type;

    typedef struct packed {
        logic       dcs_enable;
        logic [2:0] drive_code;
        logic       term_enable;
    } asl_cfg_type;

endpackage

// ### src/asl_lane_out.sv
// Serial lane output: encode tracking, PLL lock model, APB registers
// and the link-clock serializer. Expects converter words on clk and a
// link_clk at the lane bit rate (one lane bit per link_clk cycle).
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns

module asl_lane_out (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        link_clk,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        encode_pos_in,
    input  wire logic                        encode_neg_in,
    input  wire logic                        config_style_select,
    input  wire logic [1:0]                  lane_sel,
    input  wire logic                        drive_half_sel,
    input  wire logic [asl_pkg::WORD_W-1:0]  sample_ch1,
    input  wire logic [asl_pkg::WORD_W-1:0]  sample_ch2,
    output asl_pkg::asl_cfg_type             cfg,
    output logic                             nap_state,
    output asl_pkg::asl_link_type            link
);
    import asl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Core clock domain state

    typedef struct packed {
        logic              pos_s0;
        logic              pos_s1;
        logic              pos_d;
        logic              neg_s0;
        logic              neg_s1;
        logic              sty_s0;
        logic              sty_s1;
        logic [1:0]        sel_s0;
        logic [1:0]        sel_s1;
        logic              drv_s0;
        logic              drv_s1;
        logic [CNT_W-1:0]  gap;
        logic [CNT_W-1:0]  last_per;
        logic [CNT_W-1:0]  lock;
        logic              locked;
        logic              nap;
        logic              neg_hi;
        logic              se;
        logic [WORD_W-1:0] cap1;
        logic [WORD_W-1:0] cap2;
        logic              tgl;
        logic [1:0]        mode;
        logic              dcs;
        logic [2:0]        drv;
        logic              term;
        logic [1:0]        mode_eff;
        asl_cfg_type       cfg;
        logic [31:0]       rdata;
        logic              err;
    } asl_core_type;

    asl_core_type core;
    asl_core_type next_core;
    logic             edge_seen;
    logic             restart;
    logic             nap_hit;
    logic [CNT_W-1:0] diff;
    logic             par;
    logic [1:0]       mode_now;
    logic [31:0]      ctrl_word;
    logic [31:0]      stat_word;

    // Zero wait states: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign prdata    = core.rdata;
    assign pslverr   = core.err;
    assign cfg       = core.cfg;
    assign nap_state = core.nap;

    // Strap-or-register resolution of the configuration
    always_comb begin
        par      = core.sty_s1;
        mode_now = par ? core.sel_s1 : core.mode;
        if (mode_now == 2'h3) begin
            mode_now = MODE_TWO;
        end
        ctrl_word = 32'h0;
        ctrl_word[CTRL_MODE_LSB +: 2] = core.mode;
        ctrl_word[CTRL_DCS_BIT]       = core.dcs;
        ctrl_word[CTRL_DRV_LSB +: 3]  = core.drv;
        ctrl_word[CTRL_TERM_BIT]      = core.term;
        stat_word = 32'h0;
        stat_word[ST_NAP_BIT]       = core.nap;
        stat_word[ST_LOCK_BIT]      = core.locked;
        stat_word[ST_SE_BIT]        = core.se;
        stat_word[ST_MODE_LSB +: 2] = core.mode_eff;
        stat_word[ST_PAR_BIT]       = par;
        stat_word[ST_DCS_BIT]       = core.cfg.dcs_enable;
    end

    // Encode tracking, lock timer, capture and register access
    always_comb begin
        next_core = core;
        next_core.pos_s0 = encode_pos_in;
        next_core.pos_s1 = core.pos_s0;
        next_core.pos_d  = core.pos_s1;
        next_core.neg_s0 = encode_neg_in;
        next_core.neg_s1 = core.neg_s0;
        next_core.sty_s0 = config_style_select;
        next_core.sty_s1 = core.sty_s0;
        next_core.sel_s0 = lane_sel;
        next_core.sel_s1 = core.sel_s0;
        next_core.drv_s0 = drive_half_sel;
        next_core.drv_s1 = core.drv_s0;
        edge_seen = core.pos_s1 & ~core.pos_d;
        diff = (core.gap > core.last_per) ?
               core.gap - core.last_per : core.last_per - core.gap;
        restart = 1'b0;
        nap_hit = 1'b0;
        if (core.neg_s1) begin
            next_core.neg_hi = 1'b1;
        end
        if (edge_seen) begin
            // One edge latches both channels together
            next_core.cap1 = sample_ch1;
            next_core.cap2 = sample_ch2;
            next_core.tgl  = ~core.tgl;
            // Negative input never high over a period: grounded
            next_core.se     = ~core.neg_hi & ~core.neg_s1;
            next_core.neg_hi = core.neg_s1;
            next_core.gap    = '0;
            // First period after nap has no reference to compare
            next_core.last_per = core.nap ? '0 : core.gap;
            restart = core.nap | ((core.last_per != '0) &&
                                  (diff > PER_TOL));
            next_core.nap = 1'b0;
        end else begin
            if (core.gap != '1) begin
                next_core.gap = core.gap + 1'b1;
            end
            nap_hit = (core.gap >= NAP_CYC);
            if (nap_hit) begin
                next_core.nap = 1'b1;
            end
        end
        // Outputs stay invalid for the whole relock time
        if (restart | nap_hit) begin
            next_core.lock   = LOCK_CYC;
            next_core.locked = 1'b0;
        end else if (core.lock != '0) begin
            next_core.lock = core.lock - 1'b1;
        end else begin
            next_core.locked = ~core.nap;
        end
        next_core.mode_eff = mode_now;
        // Stabilizer cannot be turned off under straps
        next_core.cfg.dcs_enable  = par | core.dcs;
        next_core.cfg.drive_code  = par ?
            (core.drv_s1 ? DRV_1P75MA : DRV_3P5MA) : core.drv;
        next_core.cfg.term_enable = ~par & core.term;
        // Read data and error are latched in the setup cycle
        if (psel && !penable) begin
            next_core.err = 1'b0;
            unique case (paddr)
                CTRL_OFS: next_core.rdata = ctrl_word;
                STAT_OFS: begin
                    next_core.rdata = stat_word;
                    next_core.err   = pwrite;
                end
                default: begin
                    next_core.rdata = 32'h0;
                    next_core.err   = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite && paddr == CTRL_OFS) begin
            next_core.mode = pwdata[CTRL_MODE_LSB +: 2];
            next_core.dcs  = pwdata[CTRL_DCS_BIT];
            next_core.drv  = pwdata[CTRL_DRV_LSB +: 3];
            next_core.term = pwdata[CTRL_TERM_BIT];
        end
    end

    // Core register bank
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core          <= '0;
            core.nap      <= 1'b1;
            core.mode     <= MODE_RST;
            core.dcs      <= DCS_RST;
            core.drv      <= DRV_RST;
            core.term     <= TERM_RST;
            core.mode_eff <= MODE_RST;
            core.cfg      <= '{DCS_RST, DRV_RST, TERM_RST};
        end else begin
            core <= next_core;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link clock domain

    typedef struct packed {
        logic              tg_s0;
        logic              tg_s1;
        logic              tg_d;
        logic              val_s0;
        logic              val_s1;
        logic [1:0]        md_s0;
        logic [1:0]        md_s1;
        logic [WORD_W-1:0] h1;
        logic [WORD_W-1:0] h2;
        logic [WORD_W-1:0] sh1;
        logic [WORD_W-1:0] sh2;
        logic [3:0]        cnt;
        logic [1:0]        lmode;
        asl_link_type      out;
    } asl_lnk_type;

    asl_lnk_type lnk;
    asl_lnk_type next_lnk;
    logic              lrst_s0;
    logic              lrst_n;
    logic              first;
    logic [1:0]        m;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w2;
    logic [3:0]        last;

    assign link = lnk.out;

    // Reset asserts at once but releases on the link clock
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_s0 <= 1'b0;
            lrst_n  <= 1'b0;
        end else begin
            lrst_s0 <= 1'b1;
            lrst_n  <= lrst_s0;
        end
    end

    // Serializer: frame of 16/lanes link cycles, one bit per lane each
    always_comb begin
        next_lnk = lnk;
        next_lnk.tg_s0  = core.tgl;
        next_lnk.tg_s1  = lnk.tg_s0;
        next_lnk.tg_d   = lnk.tg_s1;
        next_lnk.val_s0 = core.locked;
        next_lnk.val_s1 = lnk.val_s0;
        next_lnk.md_s0  = core.mode_eff;
        next_lnk.md_s1  = lnk.md_s0;
        // Captured words are stable long before the toggle arrives
        if (lnk.tg_s1 != lnk.tg_d) begin
            next_lnk.h1 = core.cap1;
            next_lnk.h2 = core.cap2;
        end
        first = (lnk.cnt == 4'h0);
        // Mode only changes on a frame boundary
        m  = first ? lnk.md_s1 : lnk.lmode;
        w1 = first ? lnk.h1 : lnk.sh1;
        w2 = first ? lnk.h2 : lnk.sh2;
        unique case (m)
            MODE_FOUR: last = 4'h3;
            MODE_ONE:  last = 4'hF;
            default:   last = 4'h7;
        endcase
        if (!lnk.val_s1) begin
            // Quiet link while napping or relocking
            next_lnk.cnt = 4'h0;
            next_lnk.out = '0;
        end else begin
            next_lnk.lmode = m;
            next_lnk.cnt = (lnk.cnt == last) ? 4'h0 : lnk.cnt + 4'h1;
            // Half rate of the bit clock: data moves on both edges
            next_lnk.out.fwd_data_clock = ~lnk.cnt[0];
            next_lnk.out.frame_marker =
                (lnk.cnt <= (last >> 1));
            next_lnk.out.ch1_lane_a = w1[WORD_W-1];
            next_lnk.out.ch2_lane_a = w2[WORD_W-1];
            next_lnk.out.ch1_lane_b = (m != MODE_ONE) & w1[WORD_W-2];
            next_lnk.out.ch2_lane_b = (m != MODE_ONE) & w2[WORD_W-2];
            // Lanes c and d idle low outside four-lane mode
            next_lnk.out.ch1_lane_c = (m == MODE_FOUR) & w1[WORD_W-3];
            next_lnk.out.ch2_lane_c = (m == MODE_FOUR) & w2[WORD_W-3];
            next_lnk.out.ch1_lane_d = (m == MODE_FOUR) & w1[WORD_W-4];
            next_lnk.out.ch2_lane_d = (m == MODE_FOUR) & w2[WORD_W-4];
            unique case (m)
                MODE_FOUR: begin
                    next_lnk.sh1 = w1 << 4;
                    next_lnk.sh2 = w2 << 4;
                end
                MODE_ONE: begin
                    next_lnk.sh1 = w1 << 1;
                    next_lnk.sh2 = w2 << 1;
                end
                default: begin
                    next_lnk.sh1 = w1 << 2;
                    next_lnk.sh2 = w2 << 2;
                end
            endcase
        end
    end

    // Link register bank
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            lnk <= '0;
        end else begin
            lnk <= next_lnk;
        end
    end

endmodule

// ### tb/asl_lane_out_chk.sv
// Checker for the lane output block, watching its top ports only.
// Assumes core and link clock domains sharing the active-low reset.
`timescale 1ns/1ns
module asl_lane_out_chk (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  link_clk,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic                  encode_pos_in,
    input wire logic                  config_style_select,
    input wire logic                  drive_half_sel,
    input wire asl_pkg::asl_cfg_type  cfg,
    input wire logic                  nap_state,
    input wire asl_pkg::asl_link_type link
);
    import asl_pkg::*;

    logic        enc_q;
    logic        stopped;
    logic [7:0]  gap_cnt;
    logic [5:0]  nap_cnt;
    logic [11:0] run_cnt;

    ////////////////////////////////////////////////////////////////////
    // Idle, nap and run counts; saturate so long idles never wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enc_q   <= 1'b0;
            stopped <= 1'b1;
            gap_cnt <= 8'h00;
            nap_cnt <= 6'h00;
            run_cnt <= 12'h000;
        end else begin
            enc_q <= encode_pos_in;
            if (gap_cnt >= 8'hD7) stopped <= 1'b1;
            if (encode_pos_in != enc_q) begin
                gap_cnt <= 8'h00;
                stopped <= 1'b0;
            end else if (gap_cnt != 8'hFF) begin
                gap_cnt <= gap_cnt + 8'h01;
            end
            if (!nap_state) nap_cnt <= 6'h00;
            else if (nap_cnt != 6'h3F) nap_cnt <= nap_cnt + 6'h01;
            if (stopped) run_cnt <= 12'h000;
            else if (run_cnt != 12'hFFF) run_cnt <= run_cnt + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_unmapped_error: assert property (@(posedge clk) disable iff (!rstn)
        psel && penable && paddr != CTRL_OFS && paddr != STAT_OFS
        |-> pslverr && prdata == 32'h00000000) else $error("unmapped ok");
    a_stat_readonly: assert property (@(posedge clk) disable iff (!rstn)
        psel && penable && pwrite && paddr == STAT_OFS |-> pslverr)
        else $error("status write not refused");
    a_strap_dcs_on: assert property (
        @(posedge clk) disable iff (!rstn) config_style_select [*6]
        |-> cfg.dcs_enable && !cfg.term_enable) else $error("dcs off");
    a_strap_drive_half: assert property (
        @(posedge clk) disable iff (!rstn)
        (config_style_select && drive_half_sel) [*6]
        |-> cfg.drive_code == DRV_1P75MA) else $error("drive code");
    a_nap_on_gap: assert property (
        @(posedge clk) disable iff (!rstn) gap_cnt >= 8'hD7 |-> nap_state)
        else $error("no nap after encode stop");
    a_nap_quiet: assert property (
        @(posedge clk) disable iff (!rstn) nap_cnt >= 6'h28
        |-> link == 10'h000) else $error("link active in nap");
    a_lock_quiet: assert property (
        @(posedge clk) disable iff (!rstn)
        !stopped && run_cnt < 12'h960 |-> link == 10'h000)
        else $error("link active before relock");
    // A frame cut short by nap entry is a legal abort, not a misalignment
    a_frame_start: assert property (
        @(posedge link_clk) disable iff (!rstn)
        !nap_state && $rose(link.frame_marker)
        |-> link.fwd_data_clock ##1
            (link.frame_marker && !link.fwd_data_clock))
        else $error("frame start misaligned");
endmodule

// ### tb/asl_rx_model.sv
// Receiver model: rebuilds both channel words from lanes and frame.
// Assumes the bench gives the lane count of the mode in use.
`timescale 1ns/1ns
module asl_rx_model (
    input  wire asl_pkg::asl_link_type link,
    input  wire logic [2:0]            lanes,
    output logic [15:0]                word1,
    output logic [15:0]                word2,
    output int                         frames,
    output int                         idle_err
);
    import asl_pkg::*;
    logic [15:0] sh1 = 16'h0000;
    logic [15:0] sh2 = 16'h0000;
    logic [3:0]  l1;
    logic [3:0]  l2;
    logic        fm_q = 1'b0;
    int          cnt = 0;
    initial frames = 0;
    initial idle_err = 0;

    ////////////////////////////////////////////////////////////////////
    // Sample a quarter bit after both clock edges; data is edge aligned
    always @(link.fwd_data_clock) begin
        #12;
        if (link.frame_marker && !fm_q) cnt = 0;
        fm_q = link.frame_marker;
        l1 = {link.ch1_lane_a, link.ch1_lane_b, link.ch1_lane_c,
              link.ch1_lane_d} >> (3'h4 - lanes);
        l2 = {link.ch2_lane_a, link.ch2_lane_b, link.ch2_lane_c,
              link.ch2_lane_d} >> (3'h4 - lanes);
        sh1 = (sh1 << lanes) | {12'h000, l1};
        sh2 = (sh2 << lanes) | {12'h000, l2};
        if (lanes != 3'h4 && (link.ch1_lane_c | link.ch1_lane_d |
            link.ch2_lane_c | link.ch2_lane_d)) idle_err++;
        if (lanes == 3'h1 && (link.ch1_lane_b | link.ch2_lane_b))
            idle_err++;
        cnt++;
        if (cnt * lanes == 16) begin
            word1 = sh1;
            word2 = sh2;
            frames++;
        end
    end
endmodule

// ### tb/tb_adc_serial_lane_output.sv
// Bench for the lane output block: APB tasks, encode source, receiver.
// Assumes the package, the checker and the receiver model are compiled.
`timescale 1ns/1ns
module tb_adc_serial_lane_output;
    import asl_pkg::*;
    logic         clk = 1'b0;
    logic         link_clk = 1'b0;
    logic         rstn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h00000000;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         encode_pos_in = 1'b0;
    logic         encode_neg_in = 1'b1;
    logic         config_style_select = 1'b0;
    logic [1:0]   lane_sel = 2'h0;
    logic         drive_half_sel = 1'b0;
    logic [15:0]  sample_ch1 = 16'h0000;
    logic [15:0]  sample_ch2 = 16'h0000;
    asl_cfg_type  cfg;
    logic         nap_state;
    asl_link_type link;
    logic         enc_on = 1'b0;
    logic         se_mode = 1'b0;
    logic [3:0]   enc_div = 4'h0;
    logic [2:0]   lanes = 3'h2;
    logic [15:0]  word1;
    logic [15:0]  word2;
    logic [31:0]  rd;
    logic         er;
    int           frames;
    int           idle_err;
    int           ie;
    int           fail_count = 0;
    int           tests_run = 0;
    int           cycles = 0;
    logic [1:0]   modes [3] = '{MODE_TWO, MODE_FOUR, MODE_ONE};
    logic [2:0]   lane_n [3] = '{3'h2, 3'h4, 3'h1};
    logic [15:0]  smp [3] = '{16'hA5C3, 16'h1E87, 16'hF00D};

    asl_lane_out uut (.clk, .rstn, .link_clk, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .encode_pos_in,
        .encode_neg_in, .config_style_select, .lane_sel, .drive_half_sel,
        .sample_ch1, .sample_ch2, .cfg, .nap_state, .link);
    asl_rx_model rx (.link, .lanes, .word1, .word2, .frames, .idle_err);

    ////////////////////////////////////////////////////////////////////
    // Clocks; 48 ns link edges never meet a rising core edge
    always #5 clk = ~clk;
    always #24 link_clk = ~link_clk;

    // Encode at 5 Msps; complement toggles opposite the encode, held low when single-ended
    always @(posedge clk) begin
        enc_div <= (enc_div == 4'h9) ? 4'h0 : enc_div + 4'h1;
        if (enc_on && enc_div == 4'h9) begin
            encode_pos_in <= !encode_pos_in;
            encode_neg_in <= se_mode ? 1'b0 : encode_pos_in;
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_frames(input int n);
        int f;
        f = frames + n;
        while (frames < f) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check({31'h0, nap_state}, 32'h1);
        apb(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h00000024);
        apb(1'b0, 12'h008, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, STAT_OFS, 32'hFF);
        check({31'h0, er}, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h00000076);
        apb(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h00000076);
        check({27'h0, cfg}, 32'h1D);
        enc_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, CTRL_OFS, {30'h1, modes[i]});
            lanes <= lane_n[i];
            sample_ch1 <= smp[i];
            sample_ch2 <= ~smp[i];
            wait_frames(4);
            ie = idle_err;
            wait_frames(2);
            check({16'h0, word1}, {16'h0, smp[i]});
            check({16'h0, word2 ^ smp[i]}, 32'h0000FFFF);
            check(idle_err, ie);
        end
        se_mode <= 1'b1;
        wait_frames(3);
        apb(1'b0, STAT_OFS, 32'h0);
        check({29'h0, rd[2:0]}, 32'h6);
        se_mode <= 1'b0;
        config_style_select <= 1'b1;
        lane_sel <= MODE_FOUR;
        drive_half_sel <= 1'b1;
        lanes <= 3'h4;
        sample_ch1 <= 16'h3C96;
        wait_frames(6);
        check({16'h0, word1}, 32'h00003C96);
        check({27'h0, cfg}, 32'h10);
        apb(1'b0, STAT_OFS, 32'h0);
        check({29'h0, rd[5:3]}, 32'h5);
        enc_on <= 1'b0;
        while (nap_state !== 1'b1) @(posedge clk);
        apb(1'b0, STAT_OFS, 32'h0);
        check({30'h0, rd[1:0]}, 32'h1);
        // Unused strap code falls back to two-lane mode
        lane_sel <= 2'h3;
        repeat (4) @(posedge clk);
        apb(1'b0, STAT_OFS, 32'h0);
        check({30'h0, rd[4:3]}, {30'h0, MODE_TWO});
        complete_run();
    end
endmodule

bind asl_lane_out asl_lane_out_chk chk (.clk, .rstn, .link_clk, .psel,
    .penable, .pwrite, .paddr, .prdata, .pslverr, .encode_pos_in,
    .config_style_select, .drive_half_sel, .cfg, .nap_state, .link);
